//--- design/hmg_pkg.sv
// constants shared by the halt-mode clock gating block
package hmg_pkg;

  // wake wait after an unmasked request, in sys_clk cycles
  localparam int unsigned WAKE_VEC_CYC   = 8;
  localparam int unsigned WAKE_NOVEC_CYC = 2;
  localparam int unsigned WAKE_CNT_W     = 4;

  // second h timer count clock select codes
  localparam logic [1:0] H1_SEL_XTAL    = 2'h0;
  localparam logic [1:0] H1_SEL_RING128 = 2'h1;
  localparam logic [1:0] H1_SEL_OTHER   = 2'h2;

  // bit positions in the unit enable vector
  localparam int unsigned EN_TM16     = 0;
  localparam int unsigned EN_CNT_A    = 1;
  localparam int unsigned EN_CNT_B    = 2;
  localparam int unsigned EN_H0       = 3;
  localparam int unsigned EN_H1       = 4;
  localparam int unsigned EN_WATCH    = 5;
  localparam int unsigned EN_WDT      = 6;
  localparam int unsigned EN_UART_A   = 7;
  localparam int unsigned EN_UART_B   = 8;
  localparam int unsigned EN_CSI_A    = 9;
  localparam int unsigned EN_CSI_B    = 10;
  localparam int unsigned EN_ADC      = 11;
  localparam int unsigned EN_ATS      = 12;
  localparam int unsigned EN_MULDIV   = 13;
  localparam int unsigned EN_CLKMON   = 14;
  localparam int unsigned EN_POC      = 15;
  localparam int unsigned EN_ALWAYS   = 16;
  localparam int unsigned EN_W        = 17;

  // values after reset
  localparam logic [EN_W-1:0] EN_RST    = 17'h1ffff;
  localparam logic            XTAL_RST  = 1'b1;
  localparam logic [7:0]      PORT_RST  = 8'h00;

endpackage

//--- design/hmg_wake_if.sv
// wake request and completion between halt control and wake counter
`timescale 1ns/100ps
interface hmg_wake_if;
  logic start;
  logic vec;
  logic done;
  logic done_vec;

  modport ctl (output start, output vec, input done, input done_vec);
  modport cnt (input start, input vec, output done, output done_vec);
endinterface

//--- design/hmg_sync.sv
// three-stage synchroniser with agreement filter for pin levels
`timescale 1ns/100ps
module hmg_sync
  import hmg_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // level in and filtered level out
  input  wire logic d_in,
  output logic      q_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } hmg_sync_s;

  hmg_sync_s st_reg;
  hmg_sync_s st_next;

  // output only moves once the second and third stages agree
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_out = st_reg.q;
endmodule

//--- design/hmg_wake.sv
// wake wait counter: counts the halt release latency
`timescale 1ns/100ps
module hmg_wake
  import hmg_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // request from halt control
  hmg_wake_if.cnt   wk
);

  typedef struct packed {
    logic                  busy;
    logic                  vec;
    logic [WAKE_CNT_W-1:0] cnt;
  } hmg_wake_s;

  hmg_wake_s st_reg;
  hmg_wake_s st_next;

  // a start while busy is ignored; the control never issues one
  always_comb begin
    st_next = st_reg;
    if (!st_reg.busy && wk.start) begin
      st_next.busy = 1'b1;
      st_next.vec  = wk.vec;
      st_next.cnt  = wk.vec ? WAKE_CNT_W'(WAKE_VEC_CYC - 1)
                            : WAKE_CNT_W'(WAKE_NOVEC_CYC - 1);
    end else if (st_reg.busy) begin
      if (st_reg.cnt == '0) begin
        st_next.busy = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt - WAKE_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // completion is a one-cycle handshake level in the last wait cycle
  assign wk.done     = st_reg.busy && (st_reg.cnt == '0);
  assign wk.done_vec = st_reg.vec;
endmodule

//--- design/hmg_top.sv
// halt-mode clock gating for the sub-clock halt state
//
// Overview of operation
// (RL1) core clock withheld throughout halt
// (RL2) port latches frozen at halt entry
// (RL3) 16-bit counters run only with crystal
// (RL4) counter a needs external input without crystal
// (RL5) counter b needs external input without crystal
// (RL6) h0 needs running counter a output
// (RL7) h1 gated by crystal and ring states
// (RL8) watch timer needs crystal or subclock source
// (RL9) watchdog runs only if ring unstoppable
// (RL10) ring stoppability is a build option
// (RL11) async serial needs running counter a baud
// (RL12) clocked serial needs external serial clock
// (RL13) power-on clear stays active in halt
// (RL14) adc, auto serial, muldiv frozen without crystal
// (RL15) unmasked interrupt ends halt, maybe vectored
// (RL16) wake latency 8/9 vectored, 2/3 not
`timescale 1ns/100ps
module hmg_top
  import hmg_pkg::*;
#(
  parameter bit RING_STOPPABLE = 1'b0,
  parameter bit POC_USED       = 1'b1,
  parameter int PORT_W         = 8
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // core halt request and interrupt status
  input  wire logic              halt_req,
  input  wire logic              cpu_on_subclock,
  input  wire logic              irq_unmasked,
  input  wire logic              int_enable,
  // oscillator status, crystal from its own domain
  input  wire logic              main_crystal_clock_run,
  input  wire logic              ring_stop_sw,
  // unit clock source selections
  input  wire logic              counter_a_ext_input_sel,
  input  wire logic              counter_b_ext_input_sel,
  input  wire logic              counter_a_active,
  input  wire logic              h0_sel_counter_a_output,
  input  wire logic [1:0]        h1_clk_sel,
  input  wire logic              watch_sel_subclock,
  input  wire logic              async_serial_a_baud_cnt_a,
  input  wire logic              async_serial_b_baud_cnt_a,
  input  wire logic              clocked_serial_a_ext_clk,
  input  wire logic              clocked_serial_b_ext_clk,
  // port latch write from the core
  input  wire logic              port_wr,
  input  wire logic [PORT_W-1:0] port_wdata,
  // core state
  output logic                   cpu_clk_en,
  output logic                   halted,
  output logic                   vector_req,
  output logic                   resume_next,
  output logic [PORT_W-1:0]      port_latch,
  // unit clock enables
  output logic                   tm16_clk_en,
  output logic                   counter_a_clk_en,
  output logic                   counter_b_clk_en,
  output logic                   h0_clk_en,
  output logic                   h1_clk_en,
  output logic                   watch_clk_en,
  output logic                   wdt_clk_en,
  output logic                   async_serial_a_clk_en,
  output logic                   async_serial_b_clk_en,
  output logic                   clocked_serial_a_clk_en,
  output logic                   clocked_serial_b_clk_en,
  output logic                   adc_clk_en,
  output logic                   auto_transfer_serial_clk_en,
  output logic                   muldiv_clk_en,
  output logic                   clk_monitor_en,
  output logic                   power_on_clear_en,
  output logic                   always_on_en
);

  ////////////////////////////////////////////////////////////////////////
  // types and state

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT,
    ST_WAKE
  } hmg_state_e;

  // one struct holds all state; en is the registered enable vector
  typedef struct packed {
    hmg_state_e        state;
    logic              sub_halt;
    logic              cpu_en;
    logic              vec_pulse;
    logic              next_pulse;
    logic [PORT_W-1:0] port;
    logic [EN_W-1:0]   en;
  } hmg_top_s;

  hmg_top_s st_reg;
  hmg_top_s st_next;

  logic            xtal_run;
  logic            ring_run;
  logic            cnt_a_runs;
  logic            h1_gate;
  logic [EN_W-1:0] gate;

  hmg_wake_if wk ();

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // a unit fed from counter a output runs only while counter a counts
  function automatic logic via_counter_a(input logic sel,
                                         input logic runs);
    via_counter_a = sel && runs;
  endfunction

  // a unit survives a crystal stop only through its fallback source
  function automatic logic xtal_or(input logic xt, input logic alt);
    xtal_or = xt || alt;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // oscillator status

  // limitation: a crystal stop is seen four to five cycles late, so the
  // enables lag the oscillator by that much; the units that it feeds
  // have already lost their clock then, so the lag costs nothing
  // crystal status comes from the oscillator domain, so filter it
  hmg_sync #(
    .RST_VAL (XTAL_RST)
  ) u_xtal_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .d_in    (main_crystal_clock_run),
    .q_out   (xtal_run)
  );

  // ring counts as stopped only when the option allows a software stop
  assign ring_run = !(RING_STOPPABLE && ring_stop_sw); // RL10

  ////////////////////////////////////////////////////////////////////////
  // wake counter

  // the wait lives in its own counter so the state machine only has to
  // watch one done level; start can only rise in halt, never twice
  hmg_wake u_wake (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wk      (wk)
  );

  // request taken in the first halt cycle that sees it
  assign wk.start = (st_reg.state == ST_HALT) && irq_unmasked; // RL15
  assign wk.vec   = int_enable; // RL16

  ////////////////////////////////////////////////////////////////////////
  // gating decisions for a sub-clock halt

  // counter a only feeds other units while it really counts
  assign cnt_a_runs = xtal_or(xtal_run, counter_a_ext_input_sel) &&
                      counter_a_active;

  // second h timer follows the oscillator pair
  always_comb begin
    h1_gate = 1'b0;
    // code 2 selects some other source; it runs only with both running
    unique case ({xtal_run, ring_run})
      2'b11:   h1_gate = 1'b1; // RL7
      2'b10:   h1_gate = (h1_clk_sel == H1_SEL_XTAL); // RL7
      2'b01:   h1_gate = (h1_clk_sel == H1_SEL_RING128); // RL7
      2'b00:   h1_gate = 1'b0; // RL7
    endcase
  end

  // enable vector while halted from the subclock
  // each enable is the fallback source of its unit once the crystal
  // is gone; with the crystal running every unit keeps its clock except
  // the watchdog under a stoppable ring, the unused supervisor, and h1 and
  // the clock monitor with the ring stopped
  always_comb begin
    gate              = '0;
    gate[EN_TM16]     = xtal_run; // RL3
    gate[EN_CNT_A]    = xtal_or(xtal_run, counter_a_ext_input_sel); // RL4
    gate[EN_CNT_B]    = xtal_or(xtal_run, counter_b_ext_input_sel); // RL5
    gate[EN_H0]       = xtal_or(xtal_run,
                          via_counter_a(h0_sel_counter_a_output,
                                        cnt_a_runs)); // RL6
    gate[EN_H1]       = h1_gate;
    gate[EN_WATCH]    = xtal_or(xtal_run, watch_sel_subclock); // RL8
    // watchdog shares the ring; a stoppable ring halts it outright
    gate[EN_WDT]      = !RING_STOPPABLE; // RL9
    gate[EN_UART_A]   = xtal_or(xtal_run,
                          via_counter_a(async_serial_a_baud_cnt_a,
                                        cnt_a_runs)); // RL11
    gate[EN_UART_B]   = xtal_or(xtal_run,
                          via_counter_a(async_serial_b_baud_cnt_a,
                                        cnt_a_runs)); // RL11
    gate[EN_CSI_A]    = xtal_or(xtal_run, clocked_serial_a_ext_clk); // RL12
    gate[EN_CSI_B]    = xtal_or(xtal_run, clocked_serial_b_ext_clk); // RL12
    gate[EN_ADC]      = xtal_run; // RL14
    gate[EN_ATS]      = xtal_run; // RL14
    gate[EN_MULDIV]   = xtal_run; // RL14
    gate[EN_CLKMON]   = xtal_run && ring_run;
    gate[EN_POC]      = POC_USED; // RL13
    gate[EN_ALWAYS]   = 1'b1; // RL14
  end

  ////////////////////////////////////////////////////////////////////////
  // halt sequencing

  // the core clock and the port latch are the only state that halt
  // touches directly; everything else is the enable vector below.
  // run -> halt on a halt request, halt -> wake on an unmasked
  // request, wake -> run once the wait counter reports done
  always_comb begin
    st_next            = st_reg;
    st_next.vec_pulse  = 1'b0;
    st_next.next_pulse = 1'b0;
    unique case (st_reg.state)
      ST_RUN: begin
        // port latches only follow the core while it executes
        if (port_wr) begin
          st_next.port = port_wdata; // RL2
        end
        if (halt_req) begin
          st_next.state    = ST_HALT;
          st_next.sub_halt = cpu_on_subclock;
          st_next.cpu_en   = 1'b0; // RL1
        end
      end
      ST_HALT: begin
        if (irq_unmasked) begin
          st_next.state = ST_WAKE; // RL15
        end
      end
      ST_WAKE: begin
        // core stays frozen until the wait has fully elapsed
        if (wk.done) begin
          st_next.state      = ST_RUN; // RL16
          st_next.cpu_en     = 1'b1;
          st_next.vec_pulse  = wk.done_vec; // RL15
          st_next.next_pulse = !wk.done_vec; // RL15
        end
      end
      default: begin
        // an illegal code falls back to run rather than lock the core
        st_next.state  = ST_RUN;
        st_next.cpu_en = 1'b1;
      end
    endcase
    // main-clock halts keep units running; only sub-clock halts gate
    if (st_next.state != ST_RUN && st_next.sub_halt) begin
      st_next.en = gate;
    end else begin
      st_next.en = EN_RST;
    end
  end

  // reset releases halt just like a normal reset
  // the wake counter resets on the same edge, so no stale done remains
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '{state:      ST_RUN,
                  sub_halt:   1'b0,
                  cpu_en:     1'b1,
                  vec_pulse:  1'b0,
                  next_pulse: 1'b0,
                  port:       PORT_W'(PORT_RST),
                  en:         EN_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  // every output except halted, a decode of the state bits, is a register bit, so downstream gating cells never
  // see a glitch when several selections change in the same cycle

  assign cpu_clk_en   = st_reg.cpu_en; // RL1
  assign halted       = (st_reg.state != ST_RUN);
  assign vector_req   = st_reg.vec_pulse;
  assign resume_next  = st_reg.next_pulse;
  assign port_latch   = st_reg.port;

  assign tm16_clk_en                 = st_reg.en[EN_TM16];
  assign counter_a_clk_en            = st_reg.en[EN_CNT_A];
  assign counter_b_clk_en            = st_reg.en[EN_CNT_B];
  assign h0_clk_en                   = st_reg.en[EN_H0];
  assign h1_clk_en                   = st_reg.en[EN_H1];
  assign watch_clk_en                = st_reg.en[EN_WATCH];
  assign wdt_clk_en                  = st_reg.en[EN_WDT];
  assign async_serial_a_clk_en       = st_reg.en[EN_UART_A];
  assign async_serial_b_clk_en       = st_reg.en[EN_UART_B];
  assign clocked_serial_a_clk_en     = st_reg.en[EN_CSI_A];
  assign clocked_serial_b_clk_en     = st_reg.en[EN_CSI_B];
  assign adc_clk_en                  = st_reg.en[EN_ADC];
  assign auto_transfer_serial_clk_en = st_reg.en[EN_ATS];
  assign muldiv_clk_en               = st_reg.en[EN_MULDIV];
  assign clk_monitor_en              = st_reg.en[EN_CLKMON];
  // the supervisor is gated by build option even outside halt
  assign power_on_clear_en           = st_reg.en[EN_POC] && POC_USED;
  assign always_on_en                = st_reg.en[EN_ALWAYS];

endmodule

//--- verif/hmg_core_mdl.sv
// core model: issues halt and holds an interrupt until it is serviced
`timescale 1ns/100ps
module hmg_core_mdl (
  // clock
  input  wire logic sys_clk,
  // commands from the bench
  input  wire logic halt_cmd,
  input  wire logic irq_cmd,
  // wake results from the block
  input  wire logic vector_req,
  input  wire logic resume_next,
  // requests to the block
  output logic      halt_req,
  output logic      irq_unmasked
);
  // a request stays pending until the block reports it served
  always @(negedge sys_clk) begin
    halt_req <= halt_cmd;
    if (vector_req || resume_next)
      irq_unmasked <= 1'b0;
    else if (irq_cmd)
      irq_unmasked <= 1'b1;
  end
endmodule

//--- verif/hmg_chk.sv
// assertions on the ports of the halt clock gating top
`timescale 1ns/100ps
module hmg_chk
  import hmg_pkg::*;
#(
  parameter bit RING_STOPPABLE = 1'b0,
  parameter bit POC_USED       = 1'b1,
  parameter int PORT_W         = 8
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rstn,
  // block inputs
  input wire logic              halt_req,
  input wire logic              cpu_on_subclock,
  input wire logic              irq_unmasked,
  input wire logic              int_enable,
  input wire logic              main_crystal_clock_run,
  input wire logic              ring_stop_sw,
  input wire logic              counter_a_ext_input_sel,
  input wire logic              counter_a_active,
  input wire logic [1:0]        h1_clk_sel,
  input wire logic              async_serial_a_baud_cnt_a,
  // block outputs
  input wire logic [PORT_W-1:0] port_latch,
  input wire logic              cpu_clk_en,
  input wire logic              halted,
  input wire logic              vector_req,
  input wire logic              resume_next,
  input wire logic              tm16_clk_en,
  input wire logic              counter_a_clk_en,
  input wire logic              h1_clk_en,
  input wire logic              wdt_clk_en,
  input wire logic              async_serial_a_clk_en,
  input wire logic              adc_clk_en,
  input wire logic              auto_transfer_serial_clk_en,
  input wire logic              muldiv_clk_en,
  input wire logic              power_on_clear_en
);
  logic [2:0] xt_age_reg;
  logic       xt_q_reg;
  logic       xt;
  logic       ring_run;
  logic       h1_exp;
  logic       ua_exp;
  logic       gate_on;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // age of the crystal level; the filter hides changes for a few edges
  always_ff @(posedge sys_clk) begin
    xt_q_reg <= main_crystal_clock_run;
    if (!rstn || xt_q_reg != main_crystal_clock_run)
      xt_age_reg <= 3'h0;
    else if (xt_age_reg != 3'h7)
      xt_age_reg <= xt_age_reg + 3'h1;
  end
  // expected gate values from the current selections
  assign xt       = main_crystal_clock_run;
  assign ring_run = !(RING_STOPPABLE && ring_stop_sw);
  assign h1_exp   = xt ? (ring_run || h1_clk_sel == H1_SEL_XTAL)
                       : (ring_run && h1_clk_sel == H1_SEL_RING128);
  assign ua_exp   = xt || (async_serial_a_baud_cnt_a && counter_a_active
                           && counter_a_ext_input_sel);
  assign gate_on  = halted && cpu_on_subclock && xt_age_reg == 3'h7;

  halt_entry_a: assert property (
    !halted && halt_req |=> halted && !cpu_clk_en)
    else $error("core clock kept at halt entry");
  core_gated_a: assert property (halted |-> !cpu_clk_en)
    else $error("core clocked while halted");
  port_hold_a: assert property (
    halted && $past(halted) |-> $stable(port_latch))
    else $error("port latch moved in halt");
  wake_vec_a: assert property (
    $rose(vector_req) |-> $past(irq_unmasked, 9) && $past(int_enable, 9)
    && $past(halted) && cpu_clk_en && !resume_next)
    else $error("vectored wake latency wrong");
  wake_novec_a: assert property (
    $rose(resume_next) |-> $past(irq_unmasked, 3) && !$past(int_enable, 3)
    && $past(halted) && cpu_clk_en && !halted)
    else $error("plain wake latency wrong");
  tm16_gate_a: assert property (
    gate_on && $past(gate_on) |-> tm16_clk_en == xt)
    else $error("16-bit counter gate wrong");
  cnt_a_gate_a: assert property (gate_on && $past(gate_on) |->
    counter_a_clk_en == $past(xt || counter_a_ext_input_sel))
    else $error("counter a gate wrong");
  h1_gate_a: assert property (
    gate_on && $past(gate_on) |-> h1_clk_en == $past(h1_exp))
    else $error("second h timer gate wrong");
  uart_gate_a: assert property (gate_on && $past(gate_on) |->
    async_serial_a_clk_en == $past(ua_exp))
    else $error("async serial gate wrong");
  wdt_gate_a: assert property (
    halted && $past(halted) && cpu_on_subclock |->
    wdt_clk_en == !RING_STOPPABLE)
    else $error("watchdog gate wrong");
  frozen_units_a: assert property (gate_on && $past(gate_on) && !xt |->
    !adc_clk_en && !auto_transfer_serial_clk_en && !muldiv_clk_en)
    else $error("unit not frozen without crystal");
  poc_on_a: assert property (power_on_clear_en == POC_USED)
    else $error("power on clear gated");
  vec_c: cover property ($rose(vector_req));
  novec_c: cover property ($rose(resume_next));
  no_xtal_c: cover property (gate_on && !xt);
endmodule

bind hmg_top hmg_chk #(.RING_STOPPABLE(RING_STOPPABLE), .POC_USED(POC_USED),
  .PORT_W(PORT_W)) chk_u (.*);

//--- verif/tb.sv
// self-checking bench for the halt clock gating top
`timescale 1ns/100ps
module tb;
  import hmg_pkg::*;
  // clock, reset, commands and design inputs
  logic sys_clk = 1'b0, rstn = 1'b0, halt_cmd = 1'b0, irq_cmd = 1'b0;
  logic halt_req, irq_unmasked, cpu_on_subclock = 1'b1, int_enable = 1'b0;
  logic main_crystal_clock_run = 1'b1, ring_stop_sw = 1'b0;
  logic counter_a_ext_input_sel = 1'b0, counter_b_ext_input_sel = 1'b0;
  logic counter_a_active = 1'b0, h0_sel_counter_a_output = 1'b0;
  logic [1:0] h1_clk_sel = 2'h0;
  logic watch_sel_subclock = 1'b0, async_serial_a_baud_cnt_a = 1'b0;
  logic async_serial_b_baud_cnt_a = 1'b0, clocked_serial_a_ext_clk = 1'b0;
  logic clocked_serial_b_ext_clk = 1'b0, port_wr = 1'b0;
  logic [7:0] port_wdata = 8'h00;
  // design outputs
  logic cpu_clk_en, halted, vector_req, resume_next;
  logic [7:0] port_latch;
  logic tm16_clk_en, counter_a_clk_en, counter_b_clk_en, h0_clk_en, h1_clk_en;
  logic watch_clk_en, wdt_clk_en, async_serial_a_clk_en, async_serial_b_clk_en;
  logic clocked_serial_a_clk_en, clocked_serial_b_clk_en, adc_clk_en;
  logic auto_transfer_serial_clk_en, muldiv_clk_en, clk_monitor_en;
  logic power_on_clear_en, always_on_en;
  logic [EN_W-1:0] en_vec;
  int n_fail = 0, check_count = 0, cyc = 0;
  // stoppable ring option so that every ring state is reachable
  hmg_top #(.RING_STOPPABLE(1'b1)) dut_u (.*);
  hmg_core_mdl core_u (.*);
  assign en_vec = {always_on_en, power_on_clear_en, clk_monitor_en,
    muldiv_clk_en, auto_transfer_serial_clk_en, adc_clk_en,
    clocked_serial_b_clk_en, clocked_serial_a_clk_en, async_serial_b_clk_en,
    async_serial_a_clk_en, wdt_clk_en, watch_clk_en, h1_clk_en, h0_clk_en,
    counter_b_clk_en, counter_a_clk_en, tm16_clk_en};
  always #50 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [EN_W-1:0] seen, input logic [EN_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle halt request through the core model, then look at the core
  task automatic halt_go();
    @(posedge sys_clk) #1 halt_cmd = 1'b1;
    @(posedge sys_clk) #1 halt_cmd = 1'b0;
    @(negedge sys_clk);
    chk(EN_W'({cpu_clk_en, halted}), EN_W'(2'h1));
  endtask
  // raise an interrupt and count edges until the core clock is back
  task automatic wake(input logic v);
    int n;
    n = 0;
    @(negedge sys_clk) int_enable = v;
    @(posedge sys_clk) #1 irq_cmd = 1'b1;
    @(posedge sys_clk) #1 irq_cmd = 1'b0;
    while (cpu_clk_en !== 1'b1 && n < 20) begin
      @(posedge sys_clk) #1 n++;
    end
    chk(EN_W'(n), EN_W'(v ? WAKE_VEC_CYC : WAKE_NOVEC_CYC));
    chk(EN_W'({vector_req, resume_next, halted}), EN_W'({v, !v, 1'b0}));
  endtask
  task automatic t_port(input logic v);
    logic [7:0] d;
    d = 8'ha5 ^ {8{v}};
    @(negedge sys_clk) port_wr = 1'b1;
    port_wdata = d;
    @(negedge sys_clk) port_wr = 1'b0;
    chk(EN_W'(port_latch), EN_W'(d));
    halt_go();
    @(negedge sys_clk) port_wr = 1'b1;
    port_wdata = ~d;
    @(negedge sys_clk) port_wr = 1'b0;
    wake(v);
    chk(EN_W'(port_latch), EN_W'(d));
    $display("test port and wake %0d done", v);
  endtask
  // selections follow the bits of c; expectations worked out per unit
  task automatic t_gate(input logic [3:0] c);
    logic xt, rg, ra, h1;
    logic [EN_W-1:0] want;
    xt = c[3];
    rg = !c[2];
    ra = (xt | c[0]) & c[1];
    h1 = xt ? (rg | c[1:0] == 2'h0) : (rg & c[1:0] == 2'h1);
    want = {1'b1, 1'b1, xt & rg, xt, xt, xt, xt | c[1], xt | c[0],
      xt | (c[0] & ra), xt | (c[1] & ra), 1'b0, xt | c[0], h1,
      xt | (c[0] & ra), xt | c[1], xt | c[0], xt};
    @(negedge sys_clk) main_crystal_clock_run = xt;
    ring_stop_sw = c[2];
    counter_a_ext_input_sel = c[0];
    counter_b_ext_input_sel = c[1];
    counter_a_active = c[1];
    h0_sel_counter_a_output = c[0];
    h1_clk_sel = c[1:0] == 2'h3 ? H1_SEL_OTHER : c[1:0];
    watch_sel_subclock = c[0];
    async_serial_a_baud_cnt_a = c[1];
    async_serial_b_baud_cnt_a = c[0];
    clocked_serial_a_ext_clk = c[0];
    clocked_serial_b_ext_clk = c[1];
    cpu_on_subclock = 1'b1;
    // crystal filter needs several edges to follow the new level
    repeat (7) @(negedge sys_clk);
    halt_go();
    chk(en_vec, want);
    wake(c[0]);
    $display("test gate %0d done", c);
  endtask
  // halt from main clock gates the core only; reset ends a halt
  task automatic t_main();
    @(negedge sys_clk) cpu_on_subclock = 1'b0;
    main_crystal_clock_run = 1'b0;
    repeat (7) @(negedge sys_clk);
    halt_go();
    chk(en_vec, EN_RST);
    @(negedge sys_clk) rstn = 1'b0;
    @(negedge sys_clk) rstn = 1'b1;
    chk(EN_W'({cpu_clk_en, halted}), EN_W'(2'h2));
    $display("test main clock halt done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    chk(en_vec, EN_RST);
    chk(EN_W'({cpu_clk_en, halted, port_latch}), EN_W'(10'h200));
    $display("test reset done");
    t_port(1'b0);
    t_port(1'b1);
    for (int i = 0; i < 16; i++)
      t_gate(i[3:0]);
    t_main();
    wrap_up();
  end
endmodule
